// >>> rtl/ipa_arbiter.sv
// interrupt priority arbiter: enables, priorities, grouping, vector address
// assumes sources are level requests synchronous to clk
`include "ipa_consts.svh"
`default_nettype none
module ipa_arbiter
  import ipa_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`IPA_NSRC-1:0] src_req,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic core_irq,
  output logic [`IPA_SRC_W-1:0] core_src,
  output logic [31:0] vector_addr,
  output logic running
);
  ipa_bus_s bus;
  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  logic [`IPA_NSRC-1:0] source_enable;
  logic [2:0] preempt_bit_count;
  logic global_mask;
  logic [31:0] vt_base;
  logic [`IPA_IMPL_BITS-1:0] run_level;
  logic [`IPA_SRC_W-1:0] run_src;
  ipa_state_e state;
  ipa_state_e next_state;
  ipa_win_s win;
  ipa_prio_t prio_rdata;
  logic [`IPA_NSRC*`IPA_IMPL_BITS-1:0] levels;
  logic rd_prio_q;

  // register decode
  wire sel_ctrl = bus.addr == `IPA_OFS_CTRL;
  wire sel_group = bus.addr == `IPA_OFS_GROUP;
  wire sel_en_set = bus.addr == `IPA_OFS_EN_SET;
  wire sel_en_clr = bus.addr == `IPA_OFS_EN_CLR;
  wire sel_vt = bus.addr == `IPA_OFS_VTBASE;
  wire sel_status = bus.addr == `IPA_OFS_STATUS;
  wire sel_active = bus.addr == `IPA_OFS_ACTIVE;
  wire sel_done = bus.addr == `IPA_OFS_DONE;
  wire sel_pend = bus.addr == `IPA_OFS_PEND;
  wire sel_prio = bus.addr >= `IPA_OFS_PRIO0 &&
    bus.addr <= `IPA_OFS_PRIO_LAST && bus.addr[1:0] == 2'h0;
  // priority bytes start at their own base, not at offset zero
  wire [7:0] prio_ofs = bus.addr - `IPA_OFS_PRIO0;
  wire [`IPA_SRC_W-1:0] prio_idx = prio_ofs[`IPA_SRC_W+1:2];
  wire priority_write = bus.wr && sel_prio;
  wire grouping_write = bus.wr && sel_group;
  wire source_enable_set = bus.wr && sel_en_set;
  wire source_enable_clear = bus.wr && sel_en_clr;
  wire ack_write = bus.wr && sel_active;
  wire done_write = bus.wr && sel_done;
  wire ctrl_write = bus.wr && sel_ctrl;
  wire vt_write = bus.wr && sel_vt;

  // a mask write acts on the line at the edge that stores it
  wire next_global_mask = ctrl_write ? bus.wdata[0] : global_mask;
  wire [`IPA_NSRC-1:0] set_bits = source_enable_set ? bus.wdata : '0;
  wire [`IPA_NSRC-1:0] clr_bits = source_enable_clear ? bus.wdata : '0;
  wire [`IPA_NSRC-1:0] next_source_enable =
    (source_enable | set_bits) & ~clr_bits;
  // low address bits are dropped so the table stays on a 1 kB boundary
  wire [31:0] next_vt_base = vt_write ?
    {bus.wdata[31:`IPA_VT_ALIGN], `IPA_VT_ALIGN'(0)} : vt_base;

  ipa_prio_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr(priority_write),
    .waddr(prio_idx),
    .wdata(bus.wdata[`IPA_PRIO_W-1:0]),
    .raddr(prio_idx),
    .rdata(prio_rdata),
    .levels(levels)
  );

  // eligible sources: asserted and individually enabled
  wire [`IPA_NSRC-1:0] eligible = src_req & source_enable;

  // fixed scan from the highest number down keeps the lowest on ties
  always_comb begin
    win = '{valid: 1'b0, id: '0, level: '1};
    for (int i = `IPA_NSRC-1; i >= 0; i--) begin
      if (eligible[i] &&
          (!win.valid ||
           levels[i*`IPA_IMPL_BITS +: `IPA_IMPL_BITS] <= win.level)) begin
        win.valid = 1'b1;
        win.id = i[`IPA_SRC_W-1:0];
        win.level = levels[i*`IPA_IMPL_BITS +: `IPA_IMPL_BITS];
      end
    end
  end

  // grouping above the implemented width saturates to full preempt
  wire [2:0] eff_bits = (preempt_bit_count >= 3'(`IPA_IMPL_BITS)) ?
    3'(`IPA_IMPL_BITS) : preempt_bit_count;
  wire [`IPA_IMPL_BITS-1:0] grp_mask =
    ~(3'h7 >> eff_bits);
  wire [`IPA_IMPL_BITS-1:0] win_grp = win.level & grp_mask;
  wire [`IPA_IMPL_BITS-1:0] run_grp = run_level & grp_mask;
  // only a strictly more urgent group preempts a running handler
  wire preempt = win.valid && (win_grp < run_grp);
  wire present = (state == IPA_IDLE && win.valid) ||
    (state == IPA_RUN && preempt);

  always_comb begin
    case (state)
      IPA_IDLE: next_state = win.valid ? IPA_REQ : IPA_IDLE;
      IPA_REQ: next_state = ack_write ? IPA_RUN : IPA_REQ;
      IPA_RUN: next_state = preempt ? IPA_REQ :
        (done_write ? IPA_IDLE : IPA_RUN);
      default: next_state = IPA_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      source_enable <= '0;
      preempt_bit_count <= `IPA_GROUP_RST;
      global_mask <= 1'b1;
      vt_base <= `IPA_VT_RST;
    end else begin
      source_enable <= next_source_enable;
      if (grouping_write) begin
        preempt_bit_count <= bus.wdata[2:0];
      end
      global_mask <= next_global_mask;
      vt_base <= next_vt_base;
    end
  end

  logic next_core_irq;
  logic next_running;
  logic [`IPA_SRC_W-1:0] next_core_src;
  logic [31:0] next_vector_addr;
  logic [`IPA_IMPL_BITS-1:0] next_run_level;
  logic [`IPA_SRC_W-1:0] next_run_src;
  wire take_ack = state == IPA_REQ && ack_write;
  wire run_done = state == IPA_RUN && done_write && !preempt;

  always_comb begin
    next_core_src = core_src;
    next_vector_addr = vector_addr;
    next_run_level = run_level;
    next_run_src = run_src;
    if (present) begin
      next_core_src = win.id;
      next_vector_addr = vt_base + {25'h0, win.id, 2'h0};
    end
    // the running level is the one presented, frozen at acknowledge
    if (take_ack) begin
      next_run_level = levels[core_src*`IPA_IMPL_BITS +: `IPA_IMPL_BITS];
      next_run_src = core_src;
    end else if (run_done) begin
      next_run_level = `IPA_NO_RUN;
    end
    // mask gates the line only; enables stay untouched
    next_core_irq = (next_state == IPA_REQ) && !next_global_mask;
    next_running = next_state == IPA_RUN;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= IPA_IDLE;
      run_level <= `IPA_NO_RUN;
      run_src <= '0;
      core_irq <= 1'b0;
      core_src <= '0;
      vector_addr <= `IPA_VT_RST;
      running <= 1'b0;
    end else begin
      state <= next_state;
      core_src <= next_core_src;
      vector_addr <= next_vector_addr;
      run_level <= next_run_level;
      run_src <= next_run_src;
      core_irq <= next_core_irq;
      running <= next_running;
    end
  end

  logic [31:0] rd_mux;
  assign rd_mux = sel_ctrl ? {31'h0, global_mask} :
    sel_group ? {29'h0, preempt_bit_count} :
    (sel_en_set || sel_en_clr) ? source_enable :
    sel_vt ? vt_base :
    sel_status ? {21'h0, run_level, 3'h0, run_src} :
    sel_active ? {26'h0, win.valid, win.id} :
    sel_pend ? eligible : 32'h0;

  logic [31:0] rd_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_q <= '0;
      rd_prio_q <= 1'b0;
    end else begin
      rd_q <= bus.rd ? rd_mux : 32'h0;
      rd_prio_q <= bus.rd && sel_prio;
    end
  end
  // priority reads come from the store's registered port
  assign rdata = rd_prio_q ? {24'h0, prio_rdata} : rd_q;
endmodule
`default_nettype wire

// >>> rtl/ipa_consts.svh
// constants of the interrupt priority arbiter: offsets, fields, resets
// assumes inclusion by bare name from the package and the modules
`ifndef IPA_CONSTS_SVH
`define IPA_CONSTS_SVH
`define IPA_NSRC 32
`define IPA_SRC_W 5
`define IPA_IMPL_BITS 3
`define IPA_PRIO_W 8
`define IPA_OFS_CTRL 8'h00
`define IPA_OFS_GROUP 8'h04
`define IPA_OFS_EN_SET 8'h08
`define IPA_OFS_EN_CLR 8'h0c
`define IPA_OFS_VTBASE 8'h10
`define IPA_OFS_STATUS 8'h14
`define IPA_OFS_ACTIVE 8'h18
`define IPA_OFS_DONE 8'h1c
`define IPA_OFS_PEND 8'h20
`define IPA_OFS_PRIO0 8'h40
`define IPA_OFS_PRIO_LAST 8'hbc
`define IPA_GROUP_RST 3'h0
`define IPA_VT_ALIGN 10
`define IPA_VT_RST 32'h00000000
`define IPA_NO_RUN 3'h7
`endif

// >>> rtl/ipa_pkg.sv
// types of the interrupt priority arbiter
// assumes ipa_consts.svh lies beside it
`include "ipa_consts.svh"
`default_nettype none
package ipa_pkg;
  typedef logic [`IPA_PRIO_W-1:0] ipa_prio_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ipa_bus_s;
  typedef struct packed {
    logic valid;
    logic [`IPA_SRC_W-1:0] id;
    logic [`IPA_IMPL_BITS-1:0] level;
  } ipa_win_s;
  typedef enum logic [2:0] {
    IPA_IDLE = 3'h1,
    IPA_REQ = 3'h2,
    IPA_RUN = 3'h4
  } ipa_state_e;
endpackage
`default_nettype wire

// >>> rtl/ipa_prio_mem.sv
// per-source priority byte store with registered read port
// assumes one clock, synchronous active-high reset
`include "ipa_consts.svh"
`default_nettype none
module ipa_prio_mem
  import ipa_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr,
  input wire logic [`IPA_SRC_W-1:0] waddr,
  input wire ipa_prio_t wdata,
  input wire logic [`IPA_SRC_W-1:0] raddr,
  output ipa_prio_t rdata,
  output logic [`IPA_NSRC*`IPA_IMPL_BITS-1:0] levels
);
  ipa_prio_t mem [`IPA_NSRC];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `IPA_NSRC; i++) begin
        mem[i] <= 8'h00;
      end
      rdata <= 8'h00;
    end else begin
      if (wr) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
  // only the upper implemented bits take part in arbitration
  for (genvar g = 0; g < `IPA_NSRC; g++) begin : g_lv
    assign levels[g*`IPA_IMPL_BITS +: `IPA_IMPL_BITS] =
      mem[g][`IPA_PRIO_W-1 -: `IPA_IMPL_BITS];
  end
endmodule
`default_nettype wire

// >>> verif/ipa_arbiter_properties.sv
// checker of the arbiter core link, vector output and reset
// bound to ipa_arbiter, sees its ports only
`default_nettype none
module ipa_arbiter_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] src_req,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic core_irq,
  input wire logic [4:0] core_src,
  input wire logic [31:0] vector_addr,
  input wire logic running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] prev_req;
  always_ff @(posedge clk) prev_req <= src_req;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_vec_align: assert property (
    vector_addr[9:0] == {3'h0, core_src, 2'h0}) else $error("bad vector");
  a_irq_cause: assert property (
    $rose(core_irq) |-> prev_req[core_src]) else $error("bad source");
  a_irq_hold: assert property (
    core_irq && !wr |=> core_irq) else $error("request dropped");
  a_ack_run: assert property (
    core_irq && wr && addr == 8'h18 |=> running && !core_irq)
    else $error("ack not taken");
  a_run_cause: assert property (
    $rose(running) |-> $past(core_irq)) else $error("run without request");
  a_done_idle: assert property (
    wr && addr == 8'h1c |=> !running) else $error("done not taken");
  a_mask_gate: assert property (
    wr && addr == 8'h00 && wdata[0] |=> !core_irq) else $error("mask leak");
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !core_irq && !running) else $error("reset leak");
endmodule
bind ipa_arbiter ipa_arbiter_checker i_ipa_arbiter_checker (.clk, .sys_rst,
  .src_req, .addr, .wdata, .wr, .core_irq, .core_src, .vector_addr,
  .running);
`default_nettype wire

// >>> verif/ipa_core_model.sv
// core model: takes a presented interrupt after lat waiting cycles
// the bench turns take into the acknowledge write
`default_nettype none
module ipa_core_model (
  input wire logic clk,
  input wire logic core_irq,
  input wire logic [3:0] lat,
  output logic take
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  initial take = 1'b0;
  always @(posedge clk) begin
    cnt <= core_irq ? cnt + 4'h1 : 4'h0;
    take <= core_irq && cnt == lat;
  end
endmodule
`default_nettype wire

// >>> verif/interrupt_priority_arbiter_tb.sv
// self-checking bench of ipa_arbiter with a model core
// assumes design, checker and core model compiled first
`default_nettype none
module interrupt_priority_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, take, core_irq;
  logic [31:0] src_req = '0, wdata = '0, rdata, vector_addr, en, vt, req;
  logic [31:0] late;
  logic [7:0] addr = '0;
  logic [7:0] prio [32];
  logic [4:0] core_src, w, w2;
  logic [3:0] lat = 4'h0;
  logic running, pre;
  int failures = 0, compares = 0, cyc = 0, grp = 0;
  always #2.5 clk = ~clk;
  ipa_arbiter i_ipa_arbiter (.clk, .sys_rst, .src_req, .addr, .wdata, .wr,
    .rd, .rdata, .core_irq, .core_src, .vector_addr, .running);
  ipa_core_model i_ipa_core_model (.clk, .core_irq, .lat, .take);
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // most urgent active source, lowest number on equal top bits
  function automatic logic [4:0] best(logic [31:0] act);
    logic [3:0] lv = 4'h8;
    best = 5'h0;
    for (int i = 0; i < 32; i++)
      if (act[i] && {1'b0, prio[i][7:5]} < lv) begin
        lv = {1'b0, prio[i][7:5]};
        best = i[4:0];
      end
  endfunction
  // true when level a beats level b on its preemptable bits only
  function automatic logic urgent(logic [2:0] a, logic [2:0] b, int g);
    int s = g >= 3 ? 0 : 3 - g;
    urgent = (a >> s) < (b >> s);
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'hf452));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(8'h00, 32'h1);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h7c, 32'h0);
    rd_chk(8'h30, 32'h0);
    for (int g = 0; g < 8; g++) begin
      wr_reg(8'h04, g);
      rd_chk(8'h04, g);
    end
    vt = $urandom();
    wr_reg(8'h10, vt);
    vt[9:0] = '0;
    rd_chk(8'h10, vt);
    for (int t = 0; t < 10; t++) begin
      for (int i = 0; i < 32; i++) begin
        // first trial: equal top bits, only low bits differ
        prio[i] = t == 0 ? {3'h2, 5'($urandom())} : 8'($urandom());
        wr_reg(8'h40 + 8'(4 * i), {24'h0, prio[i]});
      end
      // source 0 always asks but stays disabled; late source held back
      late = 32'h1 << (t + 1);
      en = ($urandom() & ~32'h1) | late | (32'h1 << (t + 12));
      req = $urandom() | 32'h1 | late | (32'h1 << (t + 12));
      grp = $urandom_range(7, 0);
      wr_reg(8'h0c, ~en);
      wr_reg(8'h08, en);
      wr_reg(8'h04, grp);
      src_req <= req & ~late;
      lat <= 4'($urandom_range(9, 0));
      rd_chk(8'h0c, en);
      rd_chk(8'h20, req & en & ~late);
      chk(core_irq, 1'b0);
      w = best(req & en & ~late);
      wr_reg(8'h00, 32'h0);
      for (int k = 0; k < 20 && !core_irq; k++) @(posedge clk);
      #1 chk(core_irq, 1'b1);
      chk({27'h0, core_src}, {27'h0, w});
      chk(vector_addr, vt + {25'h0, w, 2'h0});
      rd_chk(8'h18, {26'h0, 1'b1, w});
      wr_reg(8'h00, 32'h1);
      #1 chk(core_irq, 1'b0);
      wr_reg(8'h00, 32'h0);
      for (int k = 0; k < 20 && !take; k++) @(posedge clk);
      wr_reg(8'h18, 32'h0);
      #1 chk(running, 1'b1);
      rd_chk(8'h14, {21'h0, prio[w][7:5], 3'h0, w});
      // the held-back source joins while the handler runs
      src_req <= req;
      w2 = best(req & en);
      pre = urgent(prio[w2][7:5], prio[w][7:5], grp);
      repeat (3) @(posedge clk);
      #1 chk(core_irq, pre);
      chk(running, !pre);
      if (pre) begin
        chk({27'h0, core_src}, {27'h0, w2});
        for (int k = 0; k < 20 && !take; k++) @(posedge clk);
        wr_reg(8'h18, 32'h0);
        w = w2;
      end
      // the served source drops; the next one follows after one idle cycle
      src_req <= req & ~(32'h1 << w);
      w2 = best(req & en & ~(32'h1 << w));
      wr_reg(8'h1c, 32'h0);
      repeat (2) @(posedge clk);
      #1 chk(core_irq, 1'b1);
      chk({27'h0, core_src}, {27'h0, w2});
      src_req <= '0;
      for (int k = 0; k < 20 && !take; k++) @(posedge clk);
      wr_reg(8'h18, 32'h0);
      wr_reg(8'h1c, 32'h0);
      wr_reg(8'h00, 32'h1);
      rd_chk(8'h08, en);
      chk(running, 1'b0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
